// ==== osd_decoder.sv ====
// operand specifier decoder with wishbone register access
// Operation
// - bytes are taken in memory order, opcode first, then specifier.
// - extension form takes specifier bits 5..3 as operation digit 0..7.
// - register form gives register from bits 5..3, address from mod and rm.
// - displacement bytes follow the specifier and precede immediate bytes.
// - mod 00 means zero displacement and no displacement bytes.
// - mod 00 with rm 110 uses two-byte direct address, low first.
// - mod 01 reads one byte, sign-extends it, adds to base sum.
// - mod 10 reads two bytes, low then high, adds to base sum.
// - mod 11 makes rm a register code; no address calculation.
// - rm 0..7 pick bx+si, bx+di, bp+si, bp+di, si, di, bp, bx.
// - addresses using bp default to stack segment, others to data.
// - width bit picks word or byte registers; byte codes 4..7 high.
// - embedded byte code is opcode minus base; 0..3 low, 4..7 high.
// - embedded word code 0..7 names ax, cx, dx, bx, sp, bp, si, di.
// - short target adds sign-extended byte to next instruction offset.
// - near target adds two-byte displacement to next instruction offset.
// - far pointer gives offset word first, then segment selector word.
// - immediate words are assembled low byte first, high byte second.
// - opcode alone decides immediate presence, size and signedness.
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
module osd_decoder (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [5:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic [7:0]          in_byte_i,
    input  wire logic                in_valid_i,
    input  wire osd_pkg::osd_attr_t  in_attr_i,
    output logic                     in_ready_o,
    output osd_pkg::osd_res_t        res_o,
    output logic                     done_o
);

    ////////////////////////////////////////////////////////////////////
    osd_pkg::osd_st_t  st_r;
    osd_pkg::osd_st_t  st_nxt;
    osd_pkg::osd_res_t r;
    osd_pkg::osd_imm_t ik;
    osd_pkg::osd_state_t after;
    logic              take;
    logic [1:0]        mod_w;
    logic [2:0]        rm_w;
    logic [15:0]       base_w;
    logic [15:0]       next_ip;
    logic [7:0]        ediff;

    // byte lane merge for 16-bit registers
    function automatic logic [15:0] wr16(input logic [15:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
        wr16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction

    // register code to word index and high-byte flag
    function automatic logic [3:0] map_reg(input logic [2:0] c,
                                           input logic       w);
        map_reg = w ? {c, 1'b0} : {1'b0, c[1:0], c[2]};
    endfunction

    // number of displacement bytes for a specifier
    function automatic logic [1:0] disp_n(input logic [7:0] m);
        unique case (m[osd_pkg::MOD_HI:osd_pkg::MOD_LO])
            osd_pkg::MOD_NONE:
                disp_n = (m[osd_pkg::RM_HI:osd_pkg::RM_LO]
                          == osd_pkg::RM_DIRECT) ? 2'h2 : 2'h0;
            osd_pkg::MOD_SHORT:
                disp_n = 2'h1;
            osd_pkg::MOD_LONG:
                disp_n = 2'h2;
            osd_pkg::MOD_REG:
                disp_n = 2'h0;
        endcase
    endfunction

    // register read mux
    function automatic logic [31:0] rd(input osd_pkg::osd_st_t s,
                                       input logic [5:0]       a);
        case (a)
            osd_pkg::OFS_CTRL: rd = 32'(s.en);
            osd_pkg::OFS_BX:   rd = 32'(s.bx);
            osd_pkg::OFS_BP:   rd = 32'(s.bp);
            osd_pkg::OFS_SI:   rd = 32'(s.si);
            osd_pkg::OFS_DI:   rd = 32'(s.di);
            osd_pkg::OFS_IP:   rd = 32'(s.ip);
            osd_pkg::OFS_STAT: rd = 32'({s.ready, s.fin, s.state});
            osd_pkg::OFS_EOFF: rd = 32'(s.res.eoff);
            osd_pkg::OFS_TGT:  rd = 32'(s.res.tgt);
            osd_pkg::OFS_IMM:  rd = 32'(s.res.imm);
            osd_pkg::OFS_FSEL: rd = 32'(s.res.far_sel);
            osd_pkg::OFS_SEL:
                rd = 32'(s.res[$bits(osd_pkg::osd_res_t)-1 -:
                               osd_pkg::SEL_W]);
            default:           rd = 32'h0000_0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // field split and address base
    assign take  = in_valid_i && st_r.ready;
    assign mod_w = st_r.mrm[osd_pkg::MOD_HI:osd_pkg::MOD_LO];
    assign rm_w  = st_r.mrm[osd_pkg::RM_HI:osd_pkg::RM_LO];

    always_comb
    begin
        unique case (rm_w)
            osd_pkg::RM_BX_SI: base_w = st_r.bx + st_r.si;
            osd_pkg::RM_BX_DI: base_w = st_r.bx + st_r.di;
            osd_pkg::RM_BP_SI: base_w = st_r.bp + st_r.si;
            osd_pkg::RM_BP_DI: base_w = st_r.bp + st_r.di;
            osd_pkg::RM_SI:    base_w = st_r.si;
            osd_pkg::RM_DI:    base_w = st_r.di;
            osd_pkg::RM_DIRECT:
                base_w = (mod_w == osd_pkg::MOD_NONE) ? 16'h0000 : st_r.bp;
            osd_pkg::RM_BX:    base_w = st_r.bx;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // result forming
    always_comb
    begin
        r = '0;
        next_ip = st_r.ip + 16'(st_r.len);
        ediff = st_r.opc - st_r.attr.base_op;
        r.is_ext = st_r.attr.spec && st_r.attr.ext;
        r.ext_digit = st_r.mrm[osd_pkg::REG_HI:osd_pkg::REG_LO];
        {r.reg_idx, r.reg_hi} = map_reg(
            st_r.mrm[osd_pkg::REG_HI:osd_pkg::REG_LO],
            st_r.attr.wbit);
        r.mem = st_r.attr.spec && mod_w != osd_pkg::MOD_REG;
        if (st_r.attr.spec && !r.mem)
            {r.rm_idx, r.rm_hi} = map_reg(rm_w, st_r.attr.wbit);
        r.seg_ss = r.mem && (rm_w == osd_pkg::RM_BP_SI
                   || rm_w == osd_pkg::RM_BP_DI
                   || (rm_w == osd_pkg::RM_DIRECT
                       && mod_w != osd_pkg::MOD_NONE));
        if (r.mem)
            r.eoff = base_w + st_r.disp;
        if (st_r.attr.ereg != osd_pkg::EREG_NONE)
            {r.ereg_idx, r.ereg_hi} = map_reg(ediff[2:0],
                st_r.attr.ereg == osd_pkg::EREG_WORD);
        r.len = st_r.len;
        r.imm = st_r.imm;
        r.far_sel = st_r.fsel;
        if (st_r.attr.imm == osd_pkg::IMM_FAR)
            r.tgt = st_r.imm;
        else if (st_r.attr.rel)
            r.tgt = next_ip + st_r.imm;
        else
            r.tgt = next_ip;
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.done = 1'b0;
        st_nxt.fin = 1'b0;
        ik = (st_r.state == osd_pkg::ST_OPC) ? in_attr_i.imm
                                             : st_r.attr.imm;
        after = (ik == osd_pkg::IMM_NONE) ? osd_pkg::ST_OPC
                                          : osd_pkg::ST_ILO;
        // wishbone slave, one wait state
        if (wb_cyc_i && wb_stb_i && !st_r.ack)
        begin
            st_nxt.ack = 1'b1;
            st_nxt.dat = rd(st_r, wb_adr_i);
            if (wb_we_i)
            begin
                case (wb_adr_i)
                    osd_pkg::OFS_CTRL:
                        if (wb_sel_i[0])
                            st_nxt.en = wb_dat_i[0];
                    osd_pkg::OFS_BX:
                        st_nxt.bx = wr16(st_r.bx, wb_dat_i, wb_sel_i);
                    osd_pkg::OFS_BP:
                        st_nxt.bp = wr16(st_r.bp, wb_dat_i, wb_sel_i);
                    osd_pkg::OFS_SI:
                        st_nxt.si = wr16(st_r.si, wb_dat_i, wb_sel_i);
                    osd_pkg::OFS_DI:
                        st_nxt.di = wr16(st_r.di, wb_dat_i, wb_sel_i);
                    osd_pkg::OFS_IP:
                        st_nxt.ip = wr16(st_r.ip, wb_dat_i, wb_sel_i);
                    default:
                        st_nxt.en = st_r.en;
                endcase
            end
        end
        // byte stream walk
        if (take)
        begin
            st_nxt.len = st_r.len + 4'h1;
            unique case (st_r.state)
                osd_pkg::ST_OPC:
                begin
                    st_nxt.opc = in_byte_i;
                    st_nxt.attr = in_attr_i;
                    st_nxt.len = 4'h1;
                    st_nxt.mrm = 8'h00;
                    st_nxt.disp = 16'h0000;
                    st_nxt.imm = 16'h0000;
                    st_nxt.fsel = 16'h0000;
                    st_nxt.state = in_attr_i.spec ? osd_pkg::ST_MRM
                                                  : after;
                    st_nxt.fin = !in_attr_i.spec
                                 && after == osd_pkg::ST_OPC;
                end
                osd_pkg::ST_MRM:
                begin
                    st_nxt.mrm = in_byte_i;
                    if (disp_n(in_byte_i) != 2'h0)
                        st_nxt.state = osd_pkg::ST_DLO;
                    else
                    begin
                        st_nxt.state = after;
                        st_nxt.fin = after == osd_pkg::ST_OPC;
                    end
                end
                osd_pkg::ST_DLO:
                begin
                    st_nxt.disp = {{8{in_byte_i[7]}}, in_byte_i};
                    if (disp_n(st_r.mrm) == 2'h2)
                        st_nxt.state = osd_pkg::ST_DHI;
                    else
                    begin
                        st_nxt.state = after;
                        st_nxt.fin = after == osd_pkg::ST_OPC;
                    end
                end
                osd_pkg::ST_DHI:
                begin
                    st_nxt.disp[15:8] = in_byte_i;
                    st_nxt.state = after;
                    st_nxt.fin = after == osd_pkg::ST_OPC;
                end
                osd_pkg::ST_ILO:
                begin
                    st_nxt.imm = {{8{in_byte_i[7] && (st_r.attr.imm_sgn
                                   || st_r.attr.rel)}}, in_byte_i};
                    if (st_r.attr.imm == osd_pkg::IMM_BYTE)
                    begin
                        st_nxt.state = osd_pkg::ST_OPC;
                        st_nxt.fin = 1'b1;
                    end
                    else
                        st_nxt.state = osd_pkg::ST_IHI;
                end
                osd_pkg::ST_IHI:
                begin
                    st_nxt.imm[15:8] = in_byte_i;
                    if (st_r.attr.imm == osd_pkg::IMM_FAR)
                        st_nxt.state = osd_pkg::ST_FLO;
                    else
                    begin
                        st_nxt.state = osd_pkg::ST_OPC;
                        st_nxt.fin = 1'b1;
                    end
                end
                osd_pkg::ST_FLO:
                begin
                    st_nxt.fsel = {8'h00, in_byte_i};
                    st_nxt.state = osd_pkg::ST_FHI;
                end
                osd_pkg::ST_FHI:
                begin
                    st_nxt.fsel[15:8] = in_byte_i;
                    st_nxt.state = osd_pkg::ST_OPC;
                    st_nxt.fin = 1'b1;
                end
            endcase
        end
        // publish one cycle after the last byte
        if (st_r.fin)
        begin
            st_nxt.done = 1'b1;
            st_nxt.res = r;
        end
        st_nxt.ready = st_nxt.en && !st_nxt.fin;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_r <= osd_pkg::ST_RST;
        else
            st_r <= st_nxt;
    end

    assign wb_dat_o   = st_r.dat;
    assign wb_ack_o   = st_r.ack;
    assign in_ready_o = st_r.ready;
    assign res_o      = st_r.res;
    assign done_o     = st_r.done;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking dflt_clk @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_done_pulse: assert property (
        $rose(st_r.fin) |=> st_r.done ##1 !st_r.done)
        else $error("done pulse missing after last byte");

    chk_ext_digit: assert property (
        st_r.done && st_r.res.is_ext |->
        st_r.res.ext_digit == st_r.mrm[5:3])
        else $error("extension digit wrong");

    chk_zero_disp: assert property (
        st_r.done && st_r.res.mem && mod_w == osd_pkg::MOD_NONE
        && rm_w != osd_pkg::RM_DIRECT |->
        st_r.res.eoff == base_w && st_r.res.len >= 4'h2)
        else $error("mod 00 offset not plain base");

    chk_direct_addr: assert property (
        st_r.done && st_r.res.mem && mod_w == osd_pkg::MOD_NONE
        && rm_w == osd_pkg::RM_DIRECT |->
        st_r.res.eoff == st_r.disp && st_r.res.len >= 4'h4)
        else $error("direct address wrong");

    chk_short_disp: assert property (
        st_r.done && st_r.res.mem && mod_w == osd_pkg::MOD_SHORT |->
        st_r.res.eoff == 16'(base_w + {{8{st_r.disp[7]}}, st_r.disp[7:0]}))
        else $error("short displacement wrong");

    chk_long_disp: assert property (
        st_r.done && st_r.res.mem && mod_w == osd_pkg::MOD_LONG |->
        st_r.res.eoff == 16'(base_w + st_r.disp) && st_r.res.len >= 4'h4)
        else $error("long displacement wrong");

    chk_reg_form: assert property (
        st_r.done && st_r.attr.spec && mod_w == osd_pkg::MOD_REG |->
        !st_r.res.mem && st_r.res.eoff == 16'h0000)
        else $error("register form addressed memory");

    chk_stack_seg: assert property (
        st_r.done && st_r.res.mem && (rm_w == osd_pkg::RM_BP_SI
        || rm_w == osd_pkg::RM_BP_DI) |-> st_r.res.seg_ss)
        else $error("bp address not on stack segment");

    chk_byte_reg: assert property (
        st_r.done && st_r.attr.spec && !st_r.attr.wbit |->
        st_r.res.reg_idx == {1'b0, st_r.mrm[4:3]}
        && st_r.res.reg_hi == st_r.mrm[5])
        else $error("byte register map wrong");

    chk_short_tgt: assert property (
        st_r.done && st_r.attr.rel
        && st_r.attr.imm == osd_pkg::IMM_BYTE |->
        st_r.res.tgt == 16'(st_r.ip + 16'(st_r.len)
                      + {{8{st_r.imm[7]}}, st_r.imm[7:0]}))
        else $error("short target wrong");

    chk_imm_order: assert property (
        take && st_r.state == osd_pkg::ST_IHI |=>
        st_r.imm[15:8] == $past(in_byte_i))
        else $error("immediate high byte misplaced");

endmodule

// ==== osd_pkg.sv ====
// constants and types of the operand specifier decoder
package osd_pkg;
    // register byte offsets
    localparam int         ADR_W    = 6;
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_BX   = 6'h04;
    localparam logic [5:0] OFS_BP   = 6'h08;
    localparam logic [5:0] OFS_SI   = 6'h0C;
    localparam logic [5:0] OFS_DI   = 6'h10;
    localparam logic [5:0] OFS_IP   = 6'h14;
    localparam logic [5:0] OFS_STAT = 6'h18;
    localparam logic [5:0] OFS_EOFF = 6'h1C;
    localparam logic [5:0] OFS_TGT  = 6'h20;
    localparam logic [5:0] OFS_IMM  = 6'h24;
    localparam logic [5:0] OFS_FSEL = 6'h28;
    localparam logic [5:0] OFS_SEL  = 6'h2C;
    localparam logic       CTRL_EN_RST = 1'b1;
    // operand specifier byte fields
    localparam int MOD_HI = 7;
    localparam int MOD_LO = 6;
    localparam int REG_HI = 5;
    localparam int REG_LO = 3;
    localparam int RM_HI  = 2;
    localparam int RM_LO  = 0;
    localparam logic [1:0] MOD_NONE  = 2'h0;
    localparam logic [1:0] MOD_SHORT = 2'h1;
    localparam logic [1:0] MOD_LONG  = 2'h2;
    localparam logic [1:0] MOD_REG   = 2'h3;
    localparam logic [2:0] RM_BX_SI  = 3'h0;
    localparam logic [2:0] RM_BX_DI  = 3'h1;
    localparam logic [2:0] RM_BP_SI  = 3'h2;
    localparam logic [2:0] RM_BP_DI  = 3'h3;
    localparam logic [2:0] RM_SI     = 3'h4;
    localparam logic [2:0] RM_DI     = 3'h5;
    localparam logic [2:0] RM_DIRECT = 3'h6;
    localparam logic [2:0] RM_BX     = 3'h7;
    localparam int         SEL_W     = 22;

    typedef enum logic [1:0] {IMM_NONE, IMM_BYTE, IMM_WORD, IMM_FAR}
        osd_imm_t;
    typedef enum logic [1:0] {EREG_NONE, EREG_BYTE, EREG_WORD} osd_ereg_t;

    typedef struct packed {
        logic       spec;
        logic       ext;
        osd_imm_t   imm;
        logic       imm_sgn;
        logic       rel;
        logic       wbit;
        osd_ereg_t  ereg;
        logic [7:0] base_op;
    } osd_attr_t;

    typedef struct packed {
        logic        is_ext;
        logic [2:0]  ext_digit;
        logic [2:0]  reg_idx;
        logic        reg_hi;
        logic        mem;
        logic [2:0]  rm_idx;
        logic        rm_hi;
        logic        seg_ss;
        logic [2:0]  ereg_idx;
        logic        ereg_hi;
        logic [3:0]  len;
        logic [15:0] eoff;
        logic [15:0] imm;
        logic [15:0] tgt;
        logic [15:0] far_sel;
    } osd_res_t;

    typedef enum logic [2:0] {
        ST_OPC = 3'h0,
        ST_MRM = 3'h1,
        ST_DLO = 3'h3,
        ST_DHI = 3'h2,
        ST_ILO = 3'h6,
        ST_IHI = 3'h7,
        ST_FLO = 3'h5,
        ST_FHI = 3'h4
    } osd_state_t;

    typedef struct packed {
        osd_state_t  state;
        logic        en;
        logic        fin;
        logic        done;
        logic        ack;
        logic        ready;
        logic [15:0] bx;
        logic [15:0] bp;
        logic [15:0] si;
        logic [15:0] di;
        logic [15:0] ip;
        osd_attr_t   attr;
        logic [7:0]  opc;
        logic [7:0]  mrm;
        logic [3:0]  len;
        logic [15:0] disp;
        logic [15:0] imm;
        logic [15:0] fsel;
        osd_res_t    res;
        logic [31:0] dat;
    } osd_st_t;

    localparam osd_st_t ST_RST = '{state: ST_OPC, en: CTRL_EN_RST,
                                   default: '0};
endpackage

// ==== osd_fetch_model.sv ====
// fetch queue model that feeds instruction bytes to the decoder
`timescale 1ns/10ps
module osd_fetch_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       in_ready_i,
    input  wire logic [3:0] gap_i,
    output logic      [7:0] in_byte_o,
    output logic            in_valid_o
);
    logic [7:0] q[$];
    int         cnt;

    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask

    initial
    begin
        in_byte_o  = 8'h00;
        in_valid_o = 1'b0;
        cnt        = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            in_valid_o <= 1'b0;
            cnt = 0;
        end
        else
        begin
            if (in_valid_o && in_ready_i)
            begin
                // released line shows the inverse of the last byte
                in_valid_o <= 1'b0;
                in_byte_o  <= ~in_byte_o;
                cnt = gap_i;
            end
            if (!(in_valid_o && !in_ready_i))
            begin
                if (cnt != 0)
                    cnt = cnt - 1;
                else if (q.size() != 0)
                begin
                    in_byte_o  <= q.pop_front();
                    in_valid_o <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== test_operand_specifier_decoder.sv ====
// self-checking bench of the operand specifier decoder
`timescale 1ns/10ps
module test_operand_specifier_decoder;
    localparam logic [15:0] BX_V = 16'h1234;
    localparam logic [15:0] BP_V = 16'hff00;
    localparam logic [15:0] SI_V = 16'h0011;
    localparam logic [15:0] DI_V = 16'h8001;
    localparam logic [15:0] IP_V = 16'hfff0;

    logic               clk_i;
    logic               rst_i;
    logic               cyc;
    logic               stb;
    logic               we;
    logic [5:0]         adr;
    logic [3:0]         sel;
    logic [31:0]        wdat;
    logic [31:0]        rdat;
    logic               ack;
    logic [7:0]         in_byte;
    logic               in_valid;
    logic               in_ready;
    logic [3:0]         gap;
    osd_pkg::osd_attr_t attr;
    osd_pkg::osd_res_t  res;
    osd_pkg::osd_res_t  r;
    logic               done;
    logic [31:0]        v;
    logic [15:0]        d;
    int                 errors;
    int                 n_compared;
    int                 nb;

    osd_decoder dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .in_byte_i(in_byte), .in_valid_i(in_valid), .in_attr_i(attr),
        .in_ready_o(in_ready), .res_o(res), .done_o(done));

    osd_fetch_model fm_u (.clk_i(clk_i), .rst_i(rst_i),
        .in_ready_i(in_ready), .gap_i(gap), .in_byte_o(in_byte),
        .in_valid_o(in_valid));

    ////////////////////////////////////////////////////////////////////////
    task end_sim;
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task wb_go(input logic w, input logic [5:0] a, input logic [31:0] x);
        int i;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= x;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk_i);
            #1;
            if (ack === 1'b1)
                break;
        end
        if (ack !== 1'b1)
        begin
            errors++;
            end_sim();
        end
        v = rdat;
        @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    function automatic logic [15:0] eoff_of(input logic [1:0] md,
                                            input logic [2:0] rm,
                                            input logic [15:0] dd);
        logic [15:0] b;
        case (rm)
            3'h0: b = BX_V + SI_V;
            3'h1: b = BX_V + DI_V;
            3'h2: b = BP_V + SI_V;
            3'h3: b = BP_V + DI_V;
            3'h4: b = SI_V;
            3'h5: b = DI_V;
            3'h6: b = (md == 2'h0) ? 16'h0000 : BP_V;
            default: b = BX_V;
        endcase
        return b + dd;
    endfunction

    function automatic osd_pkg::osd_attr_t mk(input logic m, input logic x,
        input osd_pkg::osd_imm_t i, input logic s, input logic rl,
        input logic w, input osd_pkg::osd_ereg_t e, input logic [7:0] bo);
        mk = '{m, x, i, s, rl, w, e, bo};
    endfunction

    // bytes are left aligned in bs, first byte in the top bits
    task dec(input osd_pkg::osd_attr_t a, input logic [39:0] bs,
             input int n, input logic [3:0] g);
        int i;
        @(posedge clk_i);
        attr <= a;
        gap  <= g;
        #1;
        for (i = 0; i < n; i++)
            fm_u.push(bs[39-8*i -: 8]);
        for (i = 0; i < 200; i++)
        begin
            @(posedge clk_i);
            #1;
            if (done === 1'b1)
                break;
        end
        if (done !== 1'b1)
        begin
            errors++;
            end_sim();
        end
        r = res;
        @(posedge clk_i);
        #1;
        chk(32'(done), 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial
    begin
        rst_i = 1'b1;
        {cyc, stb, we, adr, wdat} = '0;
        sel = 4'hf;
        gap = 4'h0;
        attr = '0;
        errors = 0;
        n_compared = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_go(1'b0, osd_pkg::OFS_CTRL, 32'h0);
        chk(v, 32'h0000_0001);
        wb_go(1'b0, osd_pkg::OFS_STAT, 32'h0);
        chk(v, 32'h0000_0010);
        wb_go(1'b0, 6'h30, 32'h0);
        chk(v, 32'h0000_0000);
        wb_go(1'b1, osd_pkg::OFS_BX, {16'h0, BX_V});
        wb_go(1'b1, osd_pkg::OFS_BP, {16'h0, BP_V});
        wb_go(1'b1, osd_pkg::OFS_SI, {16'h0, SI_V});
        wb_go(1'b1, osd_pkg::OFS_DI, {16'h0, DI_V});
        wb_go(1'b1, osd_pkg::OFS_IP, {16'h0, IP_V});
        wb_go(1'b0, osd_pkg::OFS_BX, 32'h0);
        chk(v, {16'h0, BX_V});
        // every memory form, with stalls between bytes except for rm 0 and 4
        for (int md = 0; md < 3; md++)
            for (int rm = 0; rm < 8; rm++)
            begin
                d = (md == 1) ? 16'hff80 : (md == 2) ? 16'h9234 :
                    (rm == 6) ? 16'h5678 : 16'h0000;
                nb = (md == 1) ? 1 : (md == 2 || rm == 6) ? 2 : 0;
                dec(mk(1, 0, osd_pkg::IMM_NONE, 0, 0, 1, osd_pkg::EREG_NONE,
                    8'h00), {8'h8b, md[1:0], 3'h2, rm[2:0], d[7:0], d[15:8],
                    8'h00}, 2 + nb, 4'(rm[1:0]));
                chk(32'(r.eoff),
                    32'(eoff_of(md[1:0], rm[2:0], d)));
                chk(32'(r.seg_ss),
                    32'((md != 0 && rm == 6) || rm == 2 || rm == 3));
                chk(32'(r.len), 32'(2 + nb));
                chk(32'({r.mem, r.reg_idx, r.reg_hi}),
                    32'h0000_0014);
            end
        dec(mk(1, 0, osd_pkg::IMM_NONE, 0, 0, 0, osd_pkg::EREG_NONE, 8'h00),
            40'h8a_f100_0000, 2, 4'h0);
        chk(32'({r.mem, r.rm_idx, r.rm_hi, r.reg_idx, r.reg_hi}),
            32'h0000_0025);
        chk(32'(r.eoff), 32'h0000_0000);
        dec(mk(1, 1, osd_pkg::IMM_WORD, 0, 0, 1, osd_pkg::EREG_NONE, 8'h00),
            40'h81_6801_3412, 5, 4'h2);
        chk(32'({r.is_ext, r.ext_digit}), 32'h0000_000d);
        chk(32'(r.eoff), 32'(BX_V + SI_V + 16'h0001));
        chk(32'(r.imm), 32'h0000_1234);
        for (int s = 0; s < 2; s++)
        begin
            dec(mk(0, 0, osd_pkg::IMM_BYTE, s[0], 0, 1, osd_pkg::EREG_NONE,
                8'h00), 40'h6a_8500_0000, 2, 4'h0);
            chk(32'(r.imm), s ? 32'h0000_ff85 : 32'h0000_0085);
            chk(32'(r.tgt), 32'(IP_V + 16'h0002));
        end
        dec(mk(0, 0, osd_pkg::IMM_BYTE, 0, 1, 1, osd_pkg::EREG_NONE, 8'h00),
            40'heb_7f00_0000, 2, 4'h0);
        chk(32'(r.tgt), 32'h0000_0071);
        dec(mk(0, 0, osd_pkg::IMM_WORD, 0, 1, 1, osd_pkg::EREG_NONE, 8'h00),
            40'he9_2000_0000, 3, 4'h1);
        chk(32'(r.tgt), 32'h0000_0013);
        dec(mk(0, 0, osd_pkg::IMM_FAR, 0, 0, 1, osd_pkg::EREG_NONE, 8'h00),
            40'hea_7856_3412, 5, 4'h3);
        chk({r.far_sel, r.tgt}, 32'h1234_5678);
        chk(32'(r.len), 32'h0000_0005);
        wb_go(1'b0, osd_pkg::OFS_FSEL, 32'h0);
        chk(v, 32'h0000_1234);
        dec(mk(0, 0, osd_pkg::IMM_NONE, 0, 0, 0, osd_pkg::EREG_BYTE, 8'hb0),
            40'hb5_0000_0000, 1, 4'h0);
        chk(32'({r.ereg_idx, r.ereg_hi}), 32'h0000_0003);
        dec(mk(0, 0, osd_pkg::IMM_NONE, 0, 0, 1, osd_pkg::EREG_WORD, 8'h40),
            40'h44_0000_0000, 1, 4'h0);
        chk(32'({r.ereg_idx, r.ereg_hi}), 32'h0000_0008);
        // disabled decoder refuses bytes
        wb_go(1'b1, osd_pkg::OFS_CTRL, 32'h0);
        wb_go(1'b0, osd_pkg::OFS_STAT, 32'h0);
        chk(v & 32'h0000_0010, 32'h0000_0000);
        chk(32'(in_ready), 32'h0000_0000);
        wb_go(1'b1, osd_pkg::OFS_CTRL, 32'h1);
        end_sim();
    end
endmodule
